/* File: rtl/efc_pkg.sv */
// Function
// R1 - store frames whole or first 64/128 bytes
// R2 - full policy: halt or overwrite oldest data
// R3 - selectable buffer size, report occupancy
// R4 - direction select: transmit or receive path
// R5 - 10G: skip generator frames, keep protocol
// R6 - manual trigger captures all, ignores rest
// R7 - error trigger starts on chosen error
// R8 - eight error classes from any to checksum
// R9 - field trigger on pattern at offset
// R10 - field offset limited to 0..15999
// R11 - trigger frame placed top or middle
// R12 - host start/stop commands, progress reported
// R13 - middle mode keeps half buffer pre-trigger
`default_nettype none
package efc_pkg;

    // --------------------
    // register map (byte addresses)
    // --------------------
    localparam int unsigned REG_AW     = 8;
    localparam logic [7:0] REG_CTRL    = 8'h00;
    localparam logic [7:0] REG_CFG     = 8'h04;
    localparam logic [7:0] REG_FOFS    = 8'h08;
    localparam logic [7:0] REG_PAT     = 8'h0c;
    localparam logic [7:0] REG_STAT    = 8'h10;
    localparam logic [7:0] REG_USAGE   = 8'h14;
    localparam logic [7:0] REG_TRIGPTR = 8'h18;
    localparam logic [7:0] REG_IRQ_ST  = 8'h1c;
    localparam logic [7:0] REG_IRQ_CLR = 8'h20;
    localparam logic [7:0] REG_IRQ_EN  = 8'h24;
    localparam logic [7:0] REG_RD_ADDR = 8'h28;
    localparam logic [7:0] REG_RD_DATA = 8'h2c;

    // --------------------
    // field positions
    // --------------------
    localparam int unsigned CTRL_START = 0;
    localparam int unsigned CTRL_STOP  = 1;
    localparam int unsigned CFG_SLICE  = 0;   // [1:0]
    localparam int unsigned CFG_OVW    = 2;
    localparam int unsigned CFG_SIZE   = 4;   // [5:4]
    localparam int unsigned CFG_DIR_TX = 6;
    localparam int unsigned CFG_RATE10 = 7;
    localparam int unsigned CFG_MODE   = 8;   // [9:8]
    localparam int unsigned CFG_MID    = 10;
    localparam int unsigned CFG_ETYPE  = 12;  // [14:12]
    localparam int unsigned PAT_MASK   = 8;   // [15:8]
    localparam int unsigned USAGE_SIZE = 16;  // [31:16]
    localparam int unsigned IRQ_TRIG   = 0;
    localparam int unsigned IRQ_DONE   = 1;
    localparam int unsigned IRQ_WRAP   = 2;
    localparam int unsigned IRQ_W      = 3;

    // --------------------
    // frame lengths and limits
    // --------------------
    localparam int unsigned FIDX_W = 14;
    localparam logic [13:0] FIDX_MAX  = 14'h3fff;
    localparam logic [13:0] SLICE_64  = 14'h0040;
    localparam logic [13:0] SLICE_128 = 14'h0080;
    localparam logic [13:0] FRM_MIN   = 14'h0040;  // 64
    localparam logic [13:0] FRM_MAX   = 14'h05ee;  // 1518
    localparam logic [13:0] FOFS_MAX  = 14'h3e7f;  // 15999

    // --------------------
    // encodings
    // --------------------
    typedef enum logic [1:0] {
        EFC_SLICE_WHOLE = 2'b00,
        EFC_SLICE_64    = 2'b01,
        EFC_SLICE_128   = 2'b10
    } efc_slice_t;

    typedef enum logic [1:0] {
        EFC_TRIG_MANUAL = 2'b00,
        EFC_TRIG_ERROR  = 2'b01,
        EFC_TRIG_FIELD  = 2'b10
    } efc_trig_t;

    typedef enum logic [2:0] {
        EFC_ERR_ANY      = 3'b000,
        EFC_ERR_FRAG     = 3'b001,
        EFC_ERR_OVUN     = 3'b010,
        EFC_ERR_OVER     = 3'b011,
        EFC_ERR_UNDER    = 3'b100,
        EFC_ERR_FCS      = 3'b101,
        EFC_ERR_OVER_FCS = 3'b110,
        EFC_ERR_IPCS     = 3'b111
    } efc_err_t;

    // error class selection
    function automatic logic err_match(input efc_err_t t,
                                       input logic un, input logic ov,
                                       input logic fcs, input logic ip);
        logic r;
        r = 1'b0;
        unique case (t)
            EFC_ERR_ANY:      r = un | ov | fcs | ip;
            EFC_ERR_FRAG:     r = un & fcs;
            EFC_ERR_OVUN:     r = un | ov;
            EFC_ERR_OVER:     r = ov;
            EFC_ERR_UNDER:    r = un;
            EFC_ERR_FCS:      r = fcs;
            EFC_ERR_OVER_FCS: r = ov & fcs;
            EFC_ERR_IPCS:     r = ip;
        endcase
        return r;
    endfunction

    typedef enum logic [1:0] {
        EFC_ST_IDLE    = 2'b00,
        EFC_ST_ARMED   = 2'b01,
        EFC_ST_CAPTURE = 2'b10,
        EFC_ST_DONE    = 2'b11
    } efc_state_t;

endpackage
`default_nettype wire

/* File: rtl/efc_capture.sv */
`timescale 1ns/1ps
`default_nettype none
module efc_capture
    import efc_pkg::*;
#(
    parameter int unsigned DEPTH = 4096,
    parameter int unsigned AW    = $clog2(DEPTH)
) (
    // clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        resetn_i,
    // register port
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    input  wire logic        reg_we_i,
    input  wire logic        reg_re_i,
    output logic      [31:0] reg_rdata_o,
    // transmit frame path
    input  wire logic        tx_valid_i,
    input  wire logic [7:0]  tx_data_i,
    input  wire logic        tx_sof_i,
    input  wire logic        tx_eof_i,
    input  wire logic        tx_fcs_err_i,
    input  wire logic        tx_ip_csum_err_i,
    input  wire logic        tx_gen_frame_i,
    // receive frame path
    input  wire logic        rx_valid_i,
    input  wire logic [7:0]  rx_data_i,
    input  wire logic        rx_sof_i,
    input  wire logic        rx_eof_i,
    input  wire logic        rx_fcs_err_i,
    input  wire logic        rx_ip_csum_err_i,
    // interrupt
    output logic             irq_o
);
    // --------------------
    // declarations
    // --------------------
    logic [1:0]        slice_q;
    logic              ovw_q;
    logic [1:0]        size_sel_q;
    logic              dir_tx_q;
    logic              rate10_q;
    efc_trig_t         mode_q;
    logic              mid_q;
    efc_err_t          etype_q;
    logic [13:0]       fofs_q;
    logic [7:0]        pat_q;
    logic [7:0]        pmask_q;
    logic [IRQ_W-1:0]  irq_en_q;
    logic [IRQ_W-1:0]  irq_st_q;
    logic [AW-1:0]     rd_ptr_q;
    logic [31:0]       rdata_q;

    efc_state_t        state_q;
    logic [AW-1:0]     wr_ptr_q;
    logic [AW-1:0]     fstart_q;
    logic [AW-1:0]     trig_ptr_q;
    logic [AW:0]       usage_q;
    logic [AW:0]       post_q;
    logic [AW:0]       fcnt_q;
    logic [13:0]       fidx_q;
    logic              take_q;
    logic              hit_q;

    logic [8:0]        mem [DEPTH];

    logic              s_valid, s_sof, s_eof, s_fcs, s_ip;
    logic [7:0]        s_data;
    logic              excl, active, capt, mid_eff, take, store;
    logic              last, mark, eof_evt, hit, trig_hit, wrap;
    logic              start_cmd, stop_cmd;
    logic [13:0]       cur_idx, limit;
    logic [AW:0]       size_w, half_w, fcnt_now;
    logic [AW-1:0]     mask_w, wr_nx, fstart_now;
    logic [IRQ_W-1:0]  irq_evt;
    logic [31:0]       rd_mux;
    // --------------------
    // source selection
    // --------------------
    // direction picks the transmit or receive stream [R4]
    assign s_valid = dir_tx_q ? tx_valid_i       : rx_valid_i;
    assign s_data  = dir_tx_q ? tx_data_i        : rx_data_i;
    assign s_sof   = dir_tx_q ? tx_sof_i         : rx_sof_i;
    assign s_eof   = dir_tx_q ? tx_eof_i         : rx_eof_i;
    assign s_fcs   = dir_tx_q ? tx_fcs_err_i     : rx_fcs_err_i;
    assign s_ip    = dir_tx_q ? tx_ip_csum_err_i : rx_ip_csum_err_i;
    // generator stream frames are dropped at 10G, others kept [R5]
    assign excl    = dir_tx_q & rate10_q & tx_gen_frame_i;
    // --------------------
    // buffer geometry
    // --------------------
    // selected size shrinks the ring by powers of two [R3]
    assign size_w  = (AW+1)'(DEPTH) >> size_sel_q;
    assign half_w  = size_w >> 1;
    assign mask_w  = size_w[AW-1:0] - 1'b1;
    assign wr_nx   = (wr_ptr_q + 1'b1) & mask_w;
    // --------------------
    // per-byte decisions
    // --------------------
    assign active  = (state_q == EFC_ST_ARMED) |
                     (state_q == EFC_ST_CAPTURE);
    assign capt    = (state_q == EFC_ST_CAPTURE);
    // manual mode ignores trigger position [R6]
    assign mid_eff = mid_q & (mode_q != EFC_TRIG_MANUAL);
    assign cur_idx = s_sof ? '0 : fidx_q;
    assign take    = s_valid & (s_sof ? (active & ~excl) : take_q);

    // slice length limit [R1]
    always_comb begin
        unique case (slice_q)
            EFC_SLICE_64:  limit = SLICE_64;
            EFC_SLICE_128: limit = SLICE_128;
            default:       limit = FIDX_MAX;
        endcase
    end

    assign store = take & active & (cur_idx < limit);  // [R1]
    // halt on full: top counts total, middle counts post-trigger [R2]
    assign last  = store & capt & ~ovw_q &
                   (mid_eff ? (post_q + 1'b1 >= half_w)
                            : (usage_q + 1'b1 >= size_w));
    // word bit 8 marks the last stored byte of a frame [R1]
    assign mark  = s_eof | (cur_idx == limit - 1'b1) | last;
    assign wrap  = store & capt & ovw_q & (wr_ptr_q == mask_w);  // [R2]

    assign fcnt_now   = (s_sof ? '0 : fcnt_q) + (AW+1)'(store);
    assign fstart_now = s_sof ? wr_ptr_q : fstart_q;
    assign eof_evt    = take & s_eof & active;

    // field compare at the programmed offset [R9]
    assign hit = ((cur_idx == fofs_q) &
                  (((s_data ^ pat_q) & pmask_q) == 8'h00)) |
                 (~s_sof & hit_q);

    // trigger decision at frame end [R7] [R8] [R9]
    always_comb begin
        unique case (mode_q)
            EFC_TRIG_ERROR: trig_hit = err_match(etype_q,
                                cur_idx < FRM_MIN - 1'b1,
                                cur_idx > FRM_MAX - 1'b1,
                                s_fcs, s_ip);
            EFC_TRIG_FIELD: trig_hit = hit;
            default:        trig_hit = 1'b0;
        endcase
    end
    // --------------------
    // commands
    // --------------------
    assign start_cmd = reg_we_i & (reg_addr_i == REG_CTRL) &
                       reg_wdata_i[CTRL_START];
    assign stop_cmd  = reg_we_i & (reg_addr_i == REG_CTRL) &
                       reg_wdata_i[CTRL_STOP];
    // --------------------
    // frame tracking
    // --------------------
    // byte index, ownership and match state of the frame in flight
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            fidx_q <= '0;
            take_q <= 1'b0;
            hit_q  <= 1'b0;
            fcnt_q <= '0;
        end else if (s_valid) begin
            fidx_q <= (cur_idx == FIDX_MAX) ? cur_idx : cur_idx + 1'b1;
            take_q <= take & ~s_eof & ~start_cmd;
            hit_q  <= hit;
            fcnt_q <= fcnt_now;
        end
    end
    // --------------------
    // capture control
    // --------------------
    // start arms or captures, stop ends the record [R12]
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q    <= EFC_ST_IDLE;
            wr_ptr_q   <= '0;
            fstart_q   <= '0;
            trig_ptr_q <= '0;
            usage_q    <= '0;
            post_q     <= '0;
        end else if (start_cmd) begin
            // manual mode records from the first frame on [R6]
            state_q    <= (mode_q == EFC_TRIG_MANUAL) ? EFC_ST_CAPTURE
                                                      : EFC_ST_ARMED;
            wr_ptr_q   <= '0;
            fstart_q   <= '0;
            trig_ptr_q <= '0;
            usage_q    <= '0;
            post_q     <= '0;
        end else if (stop_cmd) begin
            state_q    <= EFC_ST_DONE;  // [R12]
        end else begin
            if (s_valid && s_sof) begin
                fstart_q <= wr_ptr_q;
            end
            if (store) begin
                wr_ptr_q <= wr_nx;
                // occupancy saturates at the selected size [R3]
                if ((capt || mid_eff) && usage_q != size_w) begin
                    usage_q <= usage_q + 1'b1;
                end
                if (capt && mid_eff) begin
                    post_q <= post_q + 1'b1;
                end
                if (last) begin
                    state_q <= EFC_ST_DONE;  // [R2]
                end
            end
            if (eof_evt && state_q == EFC_ST_ARMED) begin
                if (trig_hit) begin
                    // trigger frame opens the post-trigger record [R11]
                    state_q    <= EFC_ST_CAPTURE;
                    trig_ptr_q <= fstart_now;
                    post_q     <= fcnt_now;
                    if (!mid_eff) begin
                        usage_q <= (fcnt_now > size_w) ? size_w
                                                       : fcnt_now;
                    end
                end else if (!mid_eff) begin
                    // top position: untriggered frame is discarded [R11]
                    wr_ptr_q <= fstart_now;
                end
                // middle position keeps ringing pre-trigger data [R13]
            end
        end
    end
    // --------------------
    // buffer memory
    // --------------------
    // bit 8 flags last byte, bits 7:0 hold frame data
    always_ff @(posedge clk_sys_i) begin
        if (store) begin
            mem[wr_ptr_q] <= {mark, s_data};
        end
    end
    // --------------------
    // configuration registers
    // --------------------
    // setup fields written by software
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            slice_q    <= EFC_SLICE_WHOLE;
            ovw_q      <= 1'b0;
            size_sel_q <= 2'h0;
            dir_tx_q   <= 1'b0;
            rate10_q   <= 1'b0;
            mode_q     <= EFC_TRIG_MANUAL;
            mid_q      <= 1'b0;
            etype_q    <= EFC_ERR_ANY;
        end else if (reg_we_i && reg_addr_i == REG_CFG) begin
            slice_q    <= reg_wdata_i[CFG_SLICE +: 2];
            ovw_q      <= reg_wdata_i[CFG_OVW];
            size_sel_q <= reg_wdata_i[CFG_SIZE +: 2];
            dir_tx_q   <= reg_wdata_i[CFG_DIR_TX];
            rate10_q   <= reg_wdata_i[CFG_RATE10];
            mode_q     <= efc_trig_t'(reg_wdata_i[CFG_MODE +: 2]);
            mid_q      <= reg_wdata_i[CFG_MID];
            etype_q    <= efc_err_t'(reg_wdata_i[CFG_ETYPE +: 3]);
        end
    end

    // field trigger offset and pattern
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            fofs_q  <= '0;
            pat_q   <= 8'h00;
            pmask_q <= 8'hff;
        end else if (reg_we_i && reg_addr_i == REG_FOFS) begin
            // offsets past the top are clamped [R10]
            fofs_q <= (reg_wdata_i[13:0] > FOFS_MAX) ? FOFS_MAX
                                                     : reg_wdata_i[13:0];
        end else if (reg_we_i && reg_addr_i == REG_PAT) begin
            pat_q   <= reg_wdata_i[7:0];
            pmask_q <= reg_wdata_i[PAT_MASK +: 8];
        end
    end
    // --------------------
    // interrupts
    // --------------------
    assign irq_evt[IRQ_TRIG] = eof_evt & trig_hit &
                               (state_q == EFC_ST_ARMED) &
                               ~start_cmd & ~stop_cmd;
    assign irq_evt[IRQ_DONE] = last & ~start_cmd & ~stop_cmd;
    assign irq_evt[IRQ_WRAP] = wrap & ~start_cmd & ~stop_cmd;

    // sticky status, event wins over a same-cycle clear
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_st_q <= '0;
            irq_en_q <= '0;
        end else begin
            if (reg_we_i && reg_addr_i == REG_IRQ_CLR) begin
                irq_st_q <= (irq_st_q & ~reg_wdata_i[IRQ_W-1:0]) |
                            irq_evt;
            end else begin
                irq_st_q <= irq_st_q | irq_evt;
            end
            if (reg_we_i && reg_addr_i == REG_IRQ_EN) begin
                irq_en_q <= reg_wdata_i[IRQ_W-1:0];
            end
        end
    end

    assign irq_o = |(irq_st_q & irq_en_q);
    // --------------------
    // readout
    // --------------------
    // read pointer: set by software, steps on each data read
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rd_ptr_q <= '0;
        end else if (reg_we_i && reg_addr_i == REG_RD_ADDR) begin
            rd_ptr_q <= reg_wdata_i[AW-1:0];
        end else if (reg_re_i && reg_addr_i == REG_RD_DATA) begin
            rd_ptr_q <= rd_ptr_q + 1'b1;
        end
    end

    // read mux, unmapped addresses read zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (reg_addr_i)
            REG_CFG: begin
                rd_mux[CFG_SLICE +: 2] = slice_q;
                rd_mux[CFG_OVW]        = ovw_q;
                rd_mux[CFG_SIZE +: 2]  = size_sel_q;
                rd_mux[CFG_DIR_TX]     = dir_tx_q;
                rd_mux[CFG_RATE10]     = rate10_q;
                rd_mux[CFG_MODE +: 2]  = mode_q;
                rd_mux[CFG_MID]        = mid_q;
                rd_mux[CFG_ETYPE +: 3] = etype_q;
            end
            REG_FOFS:    rd_mux[13:0] = fofs_q;
            REG_PAT:     rd_mux[15:0] = {pmask_q, pat_q};
            REG_STAT:    rd_mux[1:0]  = state_q;  // [R12]
            // progress against the selected size [R3]
            REG_USAGE: begin
                rd_mux[AW:0]                = usage_q;
                rd_mux[USAGE_SIZE +: AW+1]  = size_w;
            end
            REG_TRIGPTR: rd_mux[AW-1:0]     = trig_ptr_q;
            REG_IRQ_ST:  rd_mux[IRQ_W-1:0]  = irq_st_q;
            REG_IRQ_EN:  rd_mux[IRQ_W-1:0]  = irq_en_q;
            REG_RD_ADDR: rd_mux[AW-1:0]     = rd_ptr_q;
            REG_RD_DATA: rd_mux[8:0]        = mem[rd_ptr_q];
            default:     rd_mux             = 32'h0000_0000;
        endcase
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= reg_re_i ? rd_mux : 32'h0000_0000;
        end
    end

    assign reg_rdata_o = rdata_q;

endmodule
`default_nettype wire

/* File: test/efc_capture_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module efc_capture_chk
    import efc_pkg::*;
#(
    parameter int unsigned DEPTH = 4096
) (
    // clock, reset, register port and interrupt
    input  wire logic        clk_sys_i,
    input  wire logic        resetn_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    input  wire logic        reg_we_i,
    input  wire logic        reg_re_i,
    input  wire logic [31:0] reg_rdata_o,
    input  wire logic        irq_o
);
    // --------------------
    // register port and interrupt checks
    // --------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);

    a_rdata_quiet: assert property (
        !reg_re_i |=> reg_rdata_o == 32'h0)
        else $error("read data outside read slot");
    a_irq_masked: assert property (
        reg_we_i && reg_addr_i == REG_IRQ_EN && reg_wdata_i[2:0] == 3'h0
        |=> !irq_o) else $error("interrupt while masked");
    a_stat_width: assert property (
        reg_re_i && reg_addr_i == REG_STAT |=> reg_rdata_o[31:2] == 30'h0)
        else $error("state read has stray bits");
    a_start_runs: assert property (
        reg_we_i && reg_addr_i == REG_CTRL && reg_wdata_i[0] ##1
        reg_re_i && reg_addr_i == REG_STAT |=> reg_rdata_o[1:0] inside
        {2'h1, 2'h2}) else $error("start did not arm or capture");
    a_stop_ends: assert property (
        reg_we_i && reg_addr_i == REG_CTRL && reg_wdata_i[1:0] == 2'h2 ##1
        reg_re_i && reg_addr_i == REG_STAT |=> reg_rdata_o[1:0] inside
        {2'h0, 2'h3}) else $error("stop left capture running");
    a_cfg_back: assert property (
        reg_we_i && reg_addr_i == REG_CFG ##1 reg_re_i && reg_addr_i ==
        REG_CFG |=> (reg_rdata_o & 32'h77f7) == ($past(reg_wdata_i, 2) &
        32'h77f7)) else $error("config readback differs");
    a_fofs_clamp: assert property (
        reg_we_i && reg_addr_i == REG_FOFS ##1 reg_re_i && reg_addr_i ==
        REG_FOFS |=> reg_rdata_o[13:0] == (($past(reg_wdata_i[13:0], 2) >
        FOFS_MAX) ? FOFS_MAX : $past(reg_wdata_i[13:0], 2)))
        else $error("field offset not clamped");
    a_usage_bound: assert property (
        reg_re_i && reg_addr_i == REG_USAGE |=> reg_rdata_o[15:0] <=
        reg_rdata_o[31:16] && reg_rdata_o[31:16] <= DEPTH)
        else $error("usage beyond selected size");
endmodule
bind efc_capture efc_capture_chk #(.DEPTH(DEPTH)) efc_capture_chk_i (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
    .reg_rdata_o(reg_rdata_o), .irq_o(irq_o));
`default_nettype wire

/* File: test/efc_mac_model.sv */
`timescale 1ns/1ps
`default_nettype none
module efc_mac_model (
    // clock
    input  wire logic       clk_sys_i,
    // frame path toward the capture block
    output logic            valid_o,
    output logic [7:0]      data_o,
    output logic            sof_o,
    output logic            eof_o,
    output logic            fcs_err_o,
    output logic            ip_err_o,
    output logic            gen_o
);
    // idle path at time zero
    initial begin
        {valid_o, sof_o, eof_o} = 3'h0;
        {data_o, fcs_err_o, ip_err_o, gen_o} = 11'h0;
    end
    // one frame, byte i = base + i, flags {gen, ip, fcs}
    task automatic send(input int len, input logic [7:0] base,
                        input logic [2:0] fl);
        for (int i = 0; i < len; i++) begin
            @(posedge clk_sys_i);
            valid_o <= 1'b1;
            data_o  <= base + i[7:0];
            sof_o   <= (i == 0);
            eof_o   <= (i == len - 1);
            {gen_o, ip_err_o, fcs_err_o} <= fl;
        end
        @(posedge clk_sys_i);
        {valid_o, sof_o, eof_o} <= 3'h0;
        data_o <= ~data_o;  // stale byte never lingers
        {gen_o, ip_err_o, fcs_err_o} <= ~fl;
    endtask
endmodule
`default_nettype wire

/* File: test/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import efc_pkg::*;
    localparam int unsigned DEPTH = 256;
    typedef struct {logic [15:0] cfg; logic tx; int len;
                    logic [2:0] fl; int exp;} efc_row_t;
    logic        clk_sys, resetn, we, re, irq;
    logic        tx_v, tx_s, tx_e, tx_f, tx_p, tx_g;
    logic        rx_v, rx_s, rx_e, rx_f, rx_p;
    logic [7:0]  addr, tx_d, rx_d;
    logic [31:0] wdata, rdata, rv;
    int          error_cnt = 0, tests_run = 0, cyc = 0;
    int          elen [8] = '{80, 20, 20, 1600, 20, 80, 1600, 80};
    logic [2:0]  efl [8] = '{1, 1, 0, 0, 0, 1, 1, 2};
    // cfg, transmit path, length, flags, bytes stored
    efc_row_t    rows [9] = '{'{16'h0000, 0, 100, 0, 100},
        '{16'h0001, 0, 100, 0, 64}, '{16'h0002, 0, 200, 0, 128},
        '{16'h0003, 0, 90, 0, 90}, '{16'h7420, 0, 50, 0, 50},
        '{16'h0040, 1, 30, 4, 30}, '{16'h0040, 0, 30, 0, 0},
        '{16'h00c0, 1, 40, 4, 0}, '{16'h00c0, 1, 40, 0, 40}};

    efc_capture #(.DEPTH(DEPTH)) efc_capture_i (
        .clk_sys_i(clk_sys), .resetn_i(resetn), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re),
        .reg_rdata_o(rdata), .tx_valid_i(tx_v), .tx_data_i(tx_d),
        .tx_sof_i(tx_s), .tx_eof_i(tx_e), .tx_fcs_err_i(tx_f),
        .tx_ip_csum_err_i(tx_p), .tx_gen_frame_i(tx_g),
        .rx_valid_i(rx_v), .rx_data_i(rx_d), .rx_sof_i(rx_s),
        .rx_eof_i(rx_e), .rx_fcs_err_i(rx_f), .rx_ip_csum_err_i(rx_p),
        .irq_o(irq));
    efc_mac_model tx_mac_i (.clk_sys_i(clk_sys), .valid_o(tx_v),
        .data_o(tx_d), .sof_o(tx_s), .eof_o(tx_e), .fcs_err_o(tx_f),
        .ip_err_o(tx_p), .gen_o(tx_g));
    efc_mac_model rx_mac_i (.clk_sys_i(clk_sys), .valid_o(rx_v),
        .data_o(rx_d), .sof_o(rx_s), .eof_o(rx_e), .fcs_err_o(rx_f),
        .ip_err_o(rx_p), .gen_o());

    // --------------------
    // clock, timeout and helpers
    // --------------------
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            error_cnt++;
            finish_test();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask
    // write wa, then read ra in the very next cycle
    task automatic acc(input logic [7:0] wa, input logic [31:0] wd,
                       input logic [7:0] ra);
        @(posedge clk_sys);
        we    <= 1'b1;
        addr  <= wa;
        wdata <= wd;
        @(posedge clk_sys);
        we    <= 1'b0;
        re    <= 1'b1;
        addr  <= ra;
        @(posedge clk_sys);
        re    <= 1'b0;
        #1 rv = rdata;
    endtask
    task automatic finish_test();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // --------------------
    // main sequence
    // --------------------
    initial begin
        {resetn, we, re, addr, wdata} = 43'h0;
        repeat (10) @(posedge clk_sys);
        chk(rdata, 32'h0);
        chk({31'h0, irq}, 32'h0);
        resetn <= 1'b1;
        foreach (rows[k]) begin
            acc(REG_CFG, 32'(rows[k].cfg), REG_CFG);
            acc(REG_CTRL, 32'h1, REG_STAT);
            if (rows[k].tx) tx_mac_i.send(rows[k].len, 8'h0, rows[k].fl);
            else rx_mac_i.send(rows[k].len, 8'h0, rows[k].fl);
            acc(8'hf0, 32'h0, REG_USAGE);
            chk(rv, (DEPTH >> rows[k].cfg[5:4]) << 16 | rows[k].exp);
        end
        // halt when full, interrupt raise, mask and clear
        acc(REG_IRQ_EN, 32'h7, REG_IRQ_EN);
        chk(rv, 32'h7);
        acc(REG_CFG, 32'h0020, REG_CTRL);
        acc(REG_CTRL, 32'h1, 8'hf0);
        chk(rv, 32'h0);
        rx_mac_i.send(100, 8'h0, 3'h0);
        acc(8'hf0, 32'h0, REG_STAT);
        chk(rv, 32'h3);
        acc(8'hf0, 32'h0, REG_USAGE);
        chk(rv, 32'h00400040);
        acc(REG_RD_ADDR, 32'h3f, REG_RD_DATA);
        chk(rv, 32'h13f);
        acc(8'hf0, 32'h0, REG_IRQ_ST);
        chk(rv, 32'h2);
        chk({31'h0, irq}, 32'h1);
        acc(REG_IRQ_EN, 32'h0, REG_IRQ_EN);
        chk({31'h0, irq}, 32'h0);
        acc(REG_IRQ_CLR, 32'h7, REG_IRQ_ST);
        chk(rv, 32'h0);
        // overwrite keeps capturing and flags the wrap
        acc(REG_CFG, 32'h0024, REG_CTRL);
        acc(REG_CTRL, 32'h1, REG_STAT);
        rx_mac_i.send(100, 8'h0, 3'h0);
        acc(REG_CTRL, 32'h0, REG_STAT);
        chk(rv, 32'h2);
        acc(REG_CTRL, 32'h2, REG_STAT);
        acc(REG_IRQ_CLR, 32'h0, REG_IRQ_ST);
        chk(rv, 32'h4);
        // every error class: clean frame stays armed, bad one triggers
        for (int e = 0; e < 8; e++) begin
            acc(REG_CFG, 32'h0104 | (e << 12), REG_CFG);
            acc(REG_CTRL, 32'h1, REG_STAT);
            rx_mac_i.send(80, 8'h0, 3'h0);
            acc(REG_IRQ_CLR, 32'h7, REG_STAT);
            chk(rv, 32'h1);
            rx_mac_i.send(elen[e], 8'h0, efl[e]);
            acc(8'hf0, 32'h0, REG_IRQ_ST);
            chk({31'h0, rv[0]}, 32'h1);
        end
        // field match at offset 5, clamp of offset
        acc(REG_FOFS, 32'h3fff, REG_FOFS);
        chk(rv, 32'h3e7f);
        acc(REG_FOFS, 32'h5, REG_PAT);
        acc(REG_PAT, 32'hff05, REG_CFG);
        acc(REG_CFG, 32'h0204, REG_CFG);
        acc(REG_CTRL, 32'h1, REG_STAT);
        rx_mac_i.send(20, 8'h1, 3'h0);
        acc(8'hf0, 32'h0, REG_STAT);
        chk(rv, 32'h1);
        rx_mac_i.send(20, 8'h0, 3'h0);
        acc(8'hf0, 32'h0, REG_STAT);
        chk(rv, 32'h2);
        acc(8'hf0, 32'h0, REG_TRIGPTR);
        chk(rv, 32'h0);
        // middle position keeps pre-trigger frames
        acc(REG_CFG, 32'h0500, REG_CTRL);
        acc(REG_CTRL, 32'h1, REG_STAT);
        for (int f = 0; f < 5; f++) rx_mac_i.send(100, 8'h0, 3'(f == 3));
        acc(8'hf0, 32'h0, REG_STAT);
        chk(rv, 32'h3);
        acc(8'hf0, 32'h0, REG_TRIGPTR);
        chk(rv, 32'd44);
        finish_test();
    end
endmodule
`default_nettype wire
